// file: logic/gdr_pkg.sv
// Shared constants and types of the gap coded downlink receiver.
`default_nettype none
package gdr_pkg;
  // ---------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each).
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_MASK     = 8'h04;
  localparam logic [7:0] ADDR_STATE    = 8'h08;
  localparam logic [7:0] ADDR_CONFIG   = 8'h0C;
  localparam logic [7:0] ADDR_MEM_SEL  = 8'h10;
  localparam logic [7:0] ADDR_MEM_DATA = 8'h14;
  localparam logic [7:0] ADDR_MEM_LOCK = 8'h18;

  // ---------------------------------------------------------------------
  // Status bits (sticky, write one to clear) and mask layout.
  // ---------------------------------------------------------------------
  localparam int STS_W           = 5;
  localparam int STS_FRAME_OK    = 0;
  localparam int STS_DECODE_FAIL = 1;
  localparam int STS_BAD_FRAME   = 2;
  localparam int STS_LOCKED      = 3;
  localparam int STS_PROG_DONE   = 4;

  // ---------------------------------------------------------------------
  // Symbol length windows in field clocks.
  // ---------------------------------------------------------------------
  localparam int           CNT_W        = 7;
  localparam logic [6:0]   CNT_ZERO_MIN = 7'h10;
  localparam logic [6:0]   CNT_ZERO_MAX = 7'h20;
  localparam logic [6:0]   CNT_ONE_MIN  = 7'h30;
  localparam logic [6:0]   CNT_ONE_MAX  = 7'h40;
  localparam logic [6:0]   CNT_END      = 7'h41;

  // ---------------------------------------------------------------------
  // Frame layout, first received bit ends up in the top position.
  // ---------------------------------------------------------------------
  localparam int           BITS_W       = 6;
  localparam int           FRAME_W      = 40;
  localparam logic [5:0]   FRAME_BITS   = 6'h28;
  localparam logic [1:0]   OPCODE_WRITE = 2'h3;
  localparam int           FRM_OP_LSB   = 38;
  localparam int           FRM_LOCK     = 37;
  localparam int           FRM_DATA_LSB = 5;

  // ---------------------------------------------------------------------
  // Memory and configuration block.
  // ---------------------------------------------------------------------
  localparam int           DATA_W         = 32;
  localparam int           BLK_W          = 5;
  localparam int           NUM_BLOCKS     = 32;
  localparam int           LOCK_BIT       = 32;
  localparam int           CFG_PSK_BIT    = 0;
  localparam int           CFG_RATE32_BIT = 1;
  localparam int           CFG_LAST_READABLE_BLOCK_SETTING_LSB = 2;
  localparam logic [31:0]  CFG_DEFAULT    = 32'h0000007C;
  localparam logic [5:0]   RATE16         = 6'h10;
  localparam logic [5:0]   RATE32         = 6'h20;

  // ---------------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ      = 200;
  localparam int PROG_TIME_US = 16000;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

  typedef enum logic [3:0] {
    ST_UPLINK = 4'h1,
    ST_RX     = 4'h2,
    ST_PROG   = 4'h4,
    ST_ECHO   = 4'h8
  } gdr_state_t;
endpackage
`default_nettype wire

// file: logic/gdr_receiver.sv
// Gap coded downlink receiver with block memory, uplink and APB slave.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - After the start gap come the two opcode bits 11 and then the lock bit.
// - Then follow the 32 data bits for the target block.
// - The frame ends with 5 block address bits.
// - The block is programmed only when exactly the frame length arrived.
// - Each gap restarts a field clock counter whose value is the symbol.
// - Counts of 16 to 32 decode as zero and 48 to 64 as one.
// - Below 16 or between 32 and 48 fails; beyond 64 ends the downlink.
// - A good frame starts programming, then the block is echoed until reset.
// - Field clocks count until the gap is detected, so counts run long.
// - The default configuration is Manchester, carrier/16, blocks 1 to 31.
// - Any end of a downlink without a good frame returns the device to continuous uplink.
// - Each block pairs 32 data bits with a lock bit that blocks writes.
// - Block 0 holds the configuration, blocks 1 to 31 user data.
module gdr_receiver #(
  parameter int PROG_CYCLES = gdr_pkg::PROG_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        FIELD_CLK,
  input  wire logic        FIELD_GAP,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  output logic             UPLINK_LOAD
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [1:0] pin_in;
  logic [1:0] pin_lvl;
  logic [1:0] pin_lvl_d_reg;
  logic       fclk_rise;
  logic       gap_rise;

  assign pin_in = {FIELD_GAP, FIELD_CLK};

  // Three synchroniser flops and a level flop per pin; a level is accepted when the last two agree.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      always_ff @(posedge CLOCK) begin
        if (RST) begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          lvl_reg <= 1'b0;
        end else begin
          s1_reg <= pin_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
          end
        end
      end
      assign pin_lvl[gi] = lvl_reg;
    end
  endgenerate

  // Edge history of the filtered levels.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_lvl_d_reg <= 2'h0;
    end else begin
      pin_lvl_d_reg <= pin_lvl;
    end
  end

  assign fclk_rise = pin_lvl[0] & ~pin_lvl_d_reg[0];
  assign gap_rise  = pin_lvl[1] & ~pin_lvl_d_reg[1];

  // ---------------------------------------------------------------------
  // State, memory and frame registers
  // ---------------------------------------------------------------------
  gdr_pkg::gdr_state_t state_reg;
  logic [32:0]  mem_reg [0:gdr_pkg::NUM_BLOCKS-1];
  logic [6:0]   cnt_reg;
  logic [5:0]   bits_reg;
  logic [39:0]  frame_reg;
  logic [31:0]  prog_cnt_reg;
  logic [32:0]  prog_word_reg;
  logic [4:0]   prog_blk_reg;
  logic [4:0]   up_blk_reg;
  logic [5:0]   up_half_reg;
  logic         up_phase_reg;
  logic [4:0]   up_idx_reg;
  logic [31:0]  cfg;
  logic [4:0]   last_readable_block_setting;
  logic [5:0]   rate;
  logic [4:0]   f_addr;
  logic         sym_zero;
  logic         sym_one;
  logic         frame_good;
  logic         frame_locked;
  logic [gdr_pkg::STS_W-1:0] sts_set;

  // Block 0 is the live configuration; no separate copy to go stale.
  assign cfg    = mem_reg[0][31:0];
  assign last_readable_block_setting = cfg[gdr_pkg::CFG_LAST_READABLE_BLOCK_SETTING_LSB +: gdr_pkg::BLK_W];
  assign rate   = cfg[gdr_pkg::CFG_RATE32_BIT] ? gdr_pkg::RATE32
                                               : gdr_pkg::RATE16;

  // Symbol classification of the count latched at a gap.
  assign sym_zero = (cnt_reg >= gdr_pkg::CNT_ZERO_MIN) &&
                    (cnt_reg <= gdr_pkg::CNT_ZERO_MAX);
  assign sym_one  = (cnt_reg >= gdr_pkg::CNT_ONE_MIN) &&
                    (cnt_reg <= gdr_pkg::CNT_ONE_MAX);

  // Frame checks done when the downlink ends.
  assign f_addr       = frame_reg[gdr_pkg::BLK_W-1:0];
  assign frame_locked = mem_reg[f_addr][gdr_pkg::LOCK_BIT];
  assign frame_good   = (bits_reg == gdr_pkg::FRAME_BITS) &&
                        (frame_reg[gdr_pkg::FRM_OP_LSB +: 2] ==
                         gdr_pkg::OPCODE_WRITE) && !frame_locked;

  // Downlink sequencer; the reader keeps to the gap framing.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_reg     <= gdr_pkg::ST_UPLINK;
      cnt_reg       <= 7'h00;
      bits_reg      <= 6'h00;
      frame_reg     <= 40'h0000000000;
      prog_cnt_reg  <= 32'h00000000;
      prog_word_reg <= 33'h000000000;
      prog_blk_reg  <= 5'h00;
    end else begin
      case (state_reg)
        gdr_pkg::ST_UPLINK: begin
          if (gap_rise) begin
            state_reg <= gdr_pkg::ST_RX;
            cnt_reg   <= 7'h00;
            bits_reg  <= 6'h00;
          end
        end
        gdr_pkg::ST_RX: begin
          if (gap_rise) begin
            cnt_reg <= 7'h00;
            if (sym_zero || sym_one) begin
              frame_reg <= {frame_reg[38:0], sym_one};
              if (bits_reg != 6'h3F) begin
                bits_reg <= bits_reg + 6'h01;
              end
            end else begin
              state_reg <= gdr_pkg::ST_UPLINK;
            end
          end else if (cnt_reg == gdr_pkg::CNT_END) begin
            // Long field-on time marks the end of the downlink.
            if (frame_good) begin
              state_reg     <= gdr_pkg::ST_PROG;
              prog_cnt_reg  <= 32'h00000000;
              prog_blk_reg  <= f_addr;
              prog_word_reg <= {frame_reg[gdr_pkg::FRM_LOCK],
                                frame_reg[gdr_pkg::FRM_DATA_LSB +: 32]};
            end else begin
              state_reg <= gdr_pkg::ST_UPLINK;
            end
          end else if (fclk_rise) begin
            // Counting stops only when the gap is seen, so it runs long.
            cnt_reg <= cnt_reg + 7'h01;
          end
        end
        gdr_pkg::ST_PROG: begin
          if (prog_cnt_reg == PROG_CYCLES[31:0] - 32'h00000001) begin
            state_reg <= gdr_pkg::ST_ECHO;
          end else begin
            prog_cnt_reg <= prog_cnt_reg + 32'h00000001;
          end
        end
        gdr_pkg::ST_ECHO: begin
          state_reg <= gdr_pkg::ST_ECHO;
        end
        default: begin
          state_reg <= gdr_pkg::ST_UPLINK;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Block memory
  // ---------------------------------------------------------------------
  // Written once, when the programming time has run out.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      for (int i = 0; i < gdr_pkg::NUM_BLOCKS; i++) begin
        mem_reg[i] <= 33'h000000000;
      end
      mem_reg[0] <= {1'b0, gdr_pkg::CFG_DEFAULT};
    end else if (state_reg == gdr_pkg::ST_PROG &&
                 prog_cnt_reg == PROG_CYCLES[31:0] - 32'h00000001) begin
      mem_reg[prog_blk_reg] <= prog_word_reg;
    end
  end

  // ---------------------------------------------------------------------
  // Uplink, Manchester at the configured rate
  // ---------------------------------------------------------------------
  logic up_active;
  logic up_bit;
  assign up_active = (state_reg == gdr_pkg::ST_UPLINK) ||
                     (state_reg == gdr_pkg::ST_ECHO);
  assign up_bit    = mem_reg[up_blk_reg][5'h1F - up_idx_reg];

  // Bits go out MSB first; only the echo block repeats after a write.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      up_blk_reg   <= 5'h01;
      up_half_reg  <= 6'h00;
      up_phase_reg <= 1'b0;
      up_idx_reg   <= 5'h00;
      UPLINK_LOAD  <= 1'b0;
    end else if (!up_active) begin
      up_half_reg  <= 6'h00;
      up_phase_reg <= 1'b0;
      up_idx_reg   <= 5'h00;
      UPLINK_LOAD  <= 1'b0;
      if (state_reg == gdr_pkg::ST_PROG) begin
        up_blk_reg <= prog_blk_reg;
      end
    end else begin
      UPLINK_LOAD <= up_phase_reg ? up_bit : ~up_bit;
      if (fclk_rise) begin
        if (up_half_reg == (rate >> 1) - 6'h01) begin
          up_half_reg  <= 6'h00;
          up_phase_reg <= ~up_phase_reg;
          if (up_phase_reg) begin
            up_idx_reg <= up_idx_reg + 5'h01;
            if (up_idx_reg == 5'h1F && state_reg == gdr_pkg::ST_UPLINK) begin
              // Cycle blocks 1 to the last readable one; a setting of 0 sends block 0 alone.
              if (last_readable_block_setting == 5'h00) begin
                up_blk_reg <= 5'h00;
              end else if (up_blk_reg >= last_readable_block_setting) begin
                up_blk_reg <= 5'h01;
              end else begin
                up_blk_reg <= up_blk_reg + 5'h01;
              end
            end
          end
        end else begin
          up_half_reg <= up_half_reg + 6'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Events, status and interrupt
  // ---------------------------------------------------------------------
  logic                      rx_end;
  logic [gdr_pkg::STS_W-1:0] sts_reg;
  logic [gdr_pkg::STS_W-1:0] mask_reg;
  logic [gdr_pkg::STS_W-1:0] sts_clr;
  logic [4:0]                sel_reg;
  logic                      wr_acc;

  assign rx_end = (state_reg == gdr_pkg::ST_RX) && !gap_rise &&
                  (cnt_reg == gdr_pkg::CNT_END);

  // Event pulses, each one cycle wide.
  always_comb begin
    sts_set = '0;
    sts_set[gdr_pkg::STS_FRAME_OK]    = rx_end && frame_good;
    sts_set[gdr_pkg::STS_DECODE_FAIL] = (state_reg == gdr_pkg::ST_RX) &&
                                        gap_rise && !sym_zero && !sym_one;
    sts_set[gdr_pkg::STS_LOCKED]      = rx_end && frame_locked &&
                                        (bits_reg == gdr_pkg::FRAME_BITS);
    sts_set[gdr_pkg::STS_BAD_FRAME]   = rx_end && !frame_good &&
                                        !sts_set[gdr_pkg::STS_LOCKED];
    sts_set[gdr_pkg::STS_PROG_DONE]   = (state_reg == gdr_pkg::ST_PROG) &&
                                        (prog_cnt_reg ==
                                         PROG_CYCLES[31:0] - 32'h00000001);
  end

  assign wr_acc  = PSEL && PENABLE && PREADY && PWRITE;
  assign sts_clr = (wr_acc && PADDR == gdr_pkg::ADDR_STATUS) ?
                   PWDATA[gdr_pkg::STS_W-1:0] : '0;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sts_reg <= '0;
      IRQ     <= 1'b0;
    end else begin
      sts_reg <= (sts_reg & ~sts_clr) | sts_set;
      IRQ     <= |(sts_reg & mask_reg);
    end
  end

  // ---------------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ---------------------------------------------------------------------
  logic        setup;
  logic        mapped;
  logic [31:0] rd_val;

  assign setup = PSEL && !PENABLE;

  // Read data is chosen in the setup cycle so it is a flop in access.
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    if (PADDR == gdr_pkg::ADDR_STATUS) begin
      rd_val[gdr_pkg::STS_W-1:0] = sts_reg;
    end else if (PADDR == gdr_pkg::ADDR_MASK) begin
      rd_val[gdr_pkg::STS_W-1:0] = mask_reg;
    end else if (PADDR == gdr_pkg::ADDR_STATE) begin
      rd_val = {14'h0000, prog_blk_reg, bits_reg, 3'h0, state_reg};
    end else if (PADDR == gdr_pkg::ADDR_CONFIG) begin
      rd_val = cfg;
    end else if (PADDR == gdr_pkg::ADDR_MEM_SEL) begin
      rd_val[gdr_pkg::BLK_W-1:0] = sel_reg;
    end else if (PADDR == gdr_pkg::ADDR_MEM_DATA) begin
      rd_val = mem_reg[sel_reg][31:0];
    end else if (PADDR == gdr_pkg::ADDR_MEM_LOCK) begin
      rd_val[0] = mem_reg[sel_reg][gdr_pkg::LOCK_BIT];
    end else begin
      mapped = 1'b0;
    end
  end

  // Handshake flops; PREADY rises for exactly the access cycle.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && !mapped;
      PRDATA  <= (setup && !PWRITE && mapped) ? rd_val : 32'h00000000;
    end
  end

  // Writable registers; memory itself is changed only by the downlink.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mask_reg <= '0;
      sel_reg  <= 5'h00;
    end else if (wr_acc) begin
      if (PADDR == gdr_pkg::ADDR_MASK) begin
        mask_reg <= PWDATA[gdr_pkg::STS_W-1:0];
      end else if (PADDR == gdr_pkg::ADDR_MEM_SEL) begin
        sel_reg <= PWDATA[gdr_pkg::BLK_W-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// file: testbench/gdr_receiver_checker.sv
// Concurrent checks on the pins of the gap coded downlink receiver.
`timescale 1ns/1ps
`default_nettype none
module gdr_receiver_checker #(
  parameter int PROG_CYCLES = gdr_pkg::PROG_CYCLES
) (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        FIELD_CLK,
  input wire logic        FIELD_GAP,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        IRQ,
  input wire logic        UPLINK_LOAD
);
  // ---------------------------------------------------------------------
  // Bus phases.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // A transfer opens with setup and then waits in its access phase.
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE;
  endsequence

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  setup_ready_a: assert property (setup_s |=> PREADY)
    else $error("ready missing after setup");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("ready without a setup cycle");
  ready_once_a: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
    else $error("read data or error outside access");
  slverr_hole_a: assert property (setup_s and (PADDR > 8'h18)
    |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped address not refused");
  slverr_map_a: assert property (setup_s and (PADDR <= 8'h18
    && PADDR[1:0] == 2'b00) |=> !PSLVERR)
    else $error("mapped address refused");
  mask_off_a: assert property (access_s and (PWRITE
    && PADDR == gdr_pkg::ADDR_MASK && PWDATA[4:0] == 5'h00)
    |-> ##2 (!IRQ) [*2])
    else $error("interrupt high with all sources masked");
  status_width_a: assert property (setup_s and (!PWRITE
    && PADDR == gdr_pkg::ADDR_STATUS) |=> PRDATA[31:5] == 27'h0)
    else $error("status reads bits above its field");
  lock_width_a: assert property (setup_s and (!PWRITE
    && PADDR == gdr_pkg::ADDR_MEM_LOCK) |=> PRDATA[31:1] == 31'h0)
    else $error("lock reads bits above its field");
endmodule

bind gdr_receiver gdr_receiver_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
  .CLOCK(CLOCK), .RST(RST), .FIELD_CLK(FIELD_CLK), .FIELD_GAP(FIELD_GAP),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .IRQ(IRQ), .UPLINK_LOAD(UPLINK_LOAD));
`default_nettype wire

// file: testbench/gdr_reader_model.sv
// Behavioural base station that writes blocks by carrier gaps.
`timescale 1ns/1ps
`default_nettype none
module gdr_reader_model (
  output var logic field_clk,
  output var logic field_gap
);
  logic run;

  // The carrier runs freely and only stops around a gap, from before it rises until after it falls.
  initial begin
    run = 1'b1;
    field_clk = 1'b0;
    field_gap = 1'b0;
    forever #32 field_clk = run ? ~field_clk : 1'b0;
  end

  // The field is stopped before the gap rises, so no decaying clocks are
  // counted and the counts match what is applied; times are scaled down.
  task automatic gap();
    run = 1'b0;
    #90 field_gap = 1'b1;
    #380 field_gap = 1'b0;
    #60 run = 1'b1;
  endtask

  // Send nbits symbols, first bit on top; a bad symbol ends the frame.
  task automatic send_frame(input logic [63:0] bits, input int nbits,
                            input int bad_idx, input int bad_cnt);
    int n;
    gap();
    for (int i = 0; i < nbits; i++) begin
      n = bits[nbits-1-i] ? (i[0] ? 64 : 48) : (i[0] ? 32 : 16);
      if (i == bad_idx) begin
        n = bad_cnt;
      end
      repeat (n) @(posedge field_clk);
      gap();
      if (i == bad_idx) break;
    end
    repeat (80) @(posedge field_clk);
  endtask
endmodule
`default_nettype wire

// file: testbench/test_gap_coded_downlink_receiver.sv
// Self-checking bench of the gap coded downlink receiver.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  n_fail++; $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); \
  end end
module test_gap_coded_downlink_receiver;
  logic        CLOCK;
  logic        RST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        IRQ;
  logic        UPLINK_LOAD;
  logic        FIELD_CLK;
  logic        FIELD_GAP;
  logic [31:0] rdat;
  logic        rerr;
  int          n_fail;
  int          total_checks;
  int          bad[3] = '{15, 33, 47};
  localparam logic [31:0] DATA = 32'hA5C30F96;
  localparam logic [63:0] GOOD = {24'h0, 2'b11, 1'b1, DATA, 5'h0B};
  localparam logic [63:0] ZERO = {24'h0, 2'b11, 1'b0, 32'h0, 5'h0B};

  gdr_receiver #(.PROG_CYCLES(20)) dut (
    .CLOCK(CLOCK), .RST(RST), .FIELD_CLK(FIELD_CLK), .FIELD_GAP(FIELD_GAP),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ), .UPLINK_LOAD(UPLINK_LOAD));
  gdr_reader_model rdr (.field_clk(FIELD_CLK), .field_gap(FIELD_GAP));

  // ---------------------------------------------------------------------
  // Clock, bus tasks and report.
  // ---------------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    RST <= 1'b1;
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
  endtask

  // One transfer; an idle cycle follows so no strobe is set twice at once.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
    if (k == 20) begin
      n_fail++;
      final_report();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdat & m, e)
  endtask

  // Polling is bounded; a stuck flag ends the run.
  task automatic wait_sts(input logic [31:0] b);
    int k;
    k = 0;
    do begin
      bus(1'b0, gdr_pkg::ADDR_STATUS, 32'h0);
      k++;
    end while ((rdat & b) !== b && k < 100);
    `CHK(rdat & b, b)
    if (k == 100) begin
      n_fail++;
      final_report();
    end
  endtask

  // The uplink load must change at least once in 1500 clocks while the block is sent.
  task automatic uplink_moves();
    logic last;
    logic moved;
    last = UPLINK_LOAD;
    moved = 1'b0;
    repeat (1500) begin
      @(posedge CLOCK);
      if (UPLINK_LOAD !== last) moved = 1'b1;
    end
    `CHK(moved, 1'b1)
  endtask

  // Guard against a hang anywhere in the sequence.
  initial begin
    #480000;
    n_fail++;
    final_report();
  end

  // ---------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------
  initial begin
    RST <= 1'b1;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PWRITE <= 1'b0;
    PADDR <= 8'h00;
    PWDATA <= 32'h0;
    n_fail = 0;
    total_checks = 0;
    do_reset();
    rd_chk(gdr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    rd_chk(gdr_pkg::ADDR_STATE, 32'hF, 32'h1);
    // Last readable block 31, carrier/16, Manchester.
    rd_chk(gdr_pkg::ADDR_CONFIG, 32'hFFFFFFFF, 32'h0000007C);
    bus(1'b1, gdr_pkg::ADDR_CONFIG, 32'hFFFFFFFF);
    rd_chk(gdr_pkg::ADDR_CONFIG, 32'hFFFFFFFF, 32'h0000007C);
    bus(1'b0, 8'h1C, 32'h0);
    `CHK(rerr, 1'b1)
    bus(1'b1, gdr_pkg::ADDR_MEM_SEL, 32'h0B);
    bus(1'b1, gdr_pkg::ADDR_MASK, 32'h2);
    // Symbol lengths in the failure windows drop the frame at once.
    foreach (bad[j]) begin
      rdr.send_frame(GOOD, 40, 2, bad[j]);
      rd_chk(gdr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h2);
      `CHK(IRQ, 1'b1)
      bus(1'b1, gdr_pkg::ADDR_STATUS, 32'h2);
      rd_chk(gdr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
      `CHK(IRQ, 1'b0)
      rd_chk(gdr_pkg::ADDR_STATE, 32'hF, 32'h1);
      rd_chk(gdr_pkg::ADDR_MEM_DATA, 32'hFFFFFFFF, 32'h0);
    end
    uplink_moves();
    rdr.send_frame(ZERO >> 1, 39, 99, 0);
    rd_chk(gdr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h4);
    `CHK(IRQ, 1'b0)
    bus(1'b1, gdr_pkg::ADDR_STATUS, 32'h4);
    rdr.send_frame(ZERO ^ (64'h1 << 38), 40, 99, 0);
    rd_chk(gdr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h4);
    rd_chk(gdr_pkg::ADDR_MEM_DATA, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, gdr_pkg::ADDR_STATUS, 32'h4);
    // Boundary counts 16, 32, 48 and 64 all appear in this frame.
    rdr.send_frame(GOOD, 40, 99, 0);
    wait_sts(32'h11);
    rd_chk(gdr_pkg::ADDR_MEM_DATA, 32'hFFFFFFFF, DATA);
    rd_chk(gdr_pkg::ADDR_MEM_LOCK, 32'hFFFFFFFF, 32'h1);
    rd_chk(gdr_pkg::ADDR_STATE, 32'h3E00F, {14'h0, 5'h0B, 9'h0, 4'h8});
    uplink_moves();
    // Unmasking the pending events must raise the interrupt.
    bus(1'b1, gdr_pkg::ADDR_MASK, 32'h11);
    rd_chk(gdr_pkg::ADDR_MASK, 32'hFFFFFFFF, 32'h11);
    `CHK(IRQ, 1'b1)
    bus(1'b1, gdr_pkg::ADDR_MASK, 32'h0);
    rd_chk(gdr_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h11);
    `CHK(IRQ, 1'b0)
    do_reset();
    rd_chk(gdr_pkg::ADDR_STATE, 32'hF, 32'h1);
    final_report();
  end
endmodule
`default_nettype wire
